// ### design/nv_host_pkg.sv
package nv_host_pkg;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    // Access cycle length (least time, rounded up)
    localparam int ACCESS_TIME_PS = 45000;
    localparam int ACCESS_CYC = (ACCESS_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Turnaround gap between accesses
    localparam int GAP_TIME_PS = 10000;
    localparam int GAP_CYC = (GAP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Host pull-down of the store/busy line
    localparam int PULL_TIME_PS = 100000;
    localparam int PULL_CYC = (PULL_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Post-save lockout wait in ns (default, shortenable)
    localparam int POST_SAVE_LOCKOUT_NS = 20;
    localparam int LOCKOUT_CYC =
        (POST_SAVE_LOCKOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;

    // ----------------------------------------
    // Software sequence addresses
    // ----------------------------------------
    localparam int SEQ_LEN = 6;
    localparam logic [ADDR_W-1:0] SEQ_A0 = 20'h0_4E38;
    localparam logic [ADDR_W-1:0] SEQ_A1 = 20'h0_B1C7;
    localparam logic [ADDR_W-1:0] SEQ_A2 = 20'h0_83E0;
    localparam logic [ADDR_W-1:0] SEQ_A3 = 20'h0_7C1F;
    localparam logic [ADDR_W-1:0] SEQ_A4 = 20'h0_703F;
    localparam logic [ADDR_W-1:0] SEQ_STORE = 20'h0_8FC0;
    localparam logic [ADDR_W-1:0] SEQ_RECALL = 20'h0_4C63;
    localparam logic [ADDR_W-1:0] SEQ_SAVE_OFF = 20'h0_8B45;
    localparam logic [ADDR_W-1:0] SEQ_SAVE_ON = 20'h0_4B46;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [2:0] CMD_READ = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_SW_STORE = 3'h2;
    localparam logic [2:0] CMD_SW_RECALL = 3'h3;
    localparam logic [2:0] CMD_SAVE_OFF = 3'h4;
    localparam logic [2:0] CMD_SAVE_ON = 3'h5;
    localparam logic [2:0] CMD_HW_STORE = 3'h6;

endpackage

// ### design/nv_seq_rom.sv
`timescale 1ns/10ps
// Address of step in a six-read software sequence
module nv_seq_rom (
    input wire logic [2:0] step_in,
    input wire logic [2:0] cmd_in,
    output logic [nv_host_pkg::ADDR_W-1:0] addr_out
);

    // ----------------------------------------
    // Final address by command
    // ----------------------------------------
    logic [nv_host_pkg::ADDR_W-1:0] last_addr;
    assign last_addr =
        (cmd_in == nv_host_pkg::CMD_SW_RECALL) ? nv_host_pkg::SEQ_RECALL :
        (cmd_in == nv_host_pkg::CMD_SAVE_OFF) ? nv_host_pkg::SEQ_SAVE_OFF : // R10
        (cmd_in == nv_host_pkg::CMD_SAVE_ON) ? nv_host_pkg::SEQ_SAVE_ON :
        nv_host_pkg::SEQ_STORE;

    // Fixed prefix then command address
    always_comb begin
        case (step_in)
            3'h0: addr_out = nv_host_pkg::SEQ_A0;
            3'h1: addr_out = nv_host_pkg::SEQ_A1;
            3'h2: addr_out = nv_host_pkg::SEQ_A2;
            3'h3: addr_out = nv_host_pkg::SEQ_A3;
            3'h4: addr_out = nv_host_pkg::SEQ_A4;
            default: addr_out = last_addr;
        endcase
    end

endmodule

// ### design/nv_host_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Read: select low, output enable low, write high, sleep high, busy line high.
// R2 - Twenty address bits pick one sixteen-bit word.
// R3 - Byte selects choose which data lanes the device drives on reads.
// R4 - Device follows address changes while read stays selected.
// R5 - Write: select and write low, busy high; low byte selects write.
// R6 - Host holds address stable across the whole write strobe.
// R7 - Host keeps output enable high during writes.
// R8 - Saves come from line pull-down, software sequence, or power loss.
// R9 - Power loss disconnects the holdup capacitor and starts a save.
// R10 - Without holdup capacitor the host disables power-loss saving by sequence.
// R11 - Line and power saves need the write latch; software saves always run.
// R12 - Pulled busy line with latch set starts a save after grace delay.
// R13 - Device pulls busy line low throughout every save.
// R14 - Device drives busy line high briefly after line or software saves.
// R15 - Writes started after busy line falls are blocked until it rises.
// R16 - With latch clear, accesses stay blocked until the host releases the line.
// R17 - After busy line rises, accesses stay refused for a lockout interval.
// R18 - Restore request latched at power-up, performed when supply rises.
// R19 - Power-up restore holds busy line low and refuses accesses.
// R20 - No reads or writes while any save or restore runs.
// R21 - Saves and restores move the whole array at once.
// R22 - Host keeps write strobe inactive throughout reset.
// R23 - Software sequence: six reads at fixed addresses, write high, no intervening access.
// R24 - Combined select active only with low select low and high select high.
// R25 - Sleep request must stay high for normal operation.
module nv_host_ctrl (
    input wire logic clock_in,
    input wire logic rst_n_in,
    // User command port
    input wire logic cmd_valid_in,
    input wire logic [2:0] cmd_op_in,
    input wire logic [nv_host_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [nv_host_pkg::DATA_W-1:0] cmd_wdata_in,
    input wire logic [1:0] cmd_byte_en_in,
    output logic cmd_ready_out,
    output logic rsp_valid_out,
    output logic [nv_host_pkg::DATA_W-1:0] rsp_rdata_out,
    // Memory pins
    output logic [nv_host_pkg::ADDR_W-1:0] mem_addr_out,
    output logic chip_select_n_out,
    output logic chip_select_out,
    output logic write_strobe_n_out,
    output logic output_enable_n_out,
    output logic upper_byte_select_n_out,
    output logic lower_byte_select_n_out,
    output logic sleep_request_n_out,
    input wire logic [nv_host_pkg::DATA_W-1:0] data_pins_in,
    output logic [nv_host_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe_out,
    input wire logic store_busy_line_in,
    output logic store_busy_line_out,
    output logic store_busy_line_oe_out
);

    // ----------------------------------------
    // State and registers
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_BUSY, ST_ACCESS, ST_GAP, ST_PULL, ST_LOCKOUT
    } state_t;

    state_t state_q, state_d;
    logic [nv_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [2:0] op_q;
    logic [2:0] step_q;
    logic [nv_host_pkg::ADDR_W-1:0] addr_q;
    logic [nv_host_pkg::DATA_W-1:0] wdata_q;
    logic [1:0] ben_q;
    logic [nv_host_pkg::ADDR_W-1:0] seq_addr;

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    function automatic logic is_seq_op(input logic [2:0] op);
        is_seq_op = (op == nv_host_pkg::CMD_SW_STORE) || (op == nv_host_pkg::CMD_SW_RECALL) ||
            (op == nv_host_pkg::CMD_SAVE_OFF) || (op == nv_host_pkg::CMD_SAVE_ON);
    endfunction

    wire line_high = store_busy_line_in;
    wire take_cmd = cmd_valid_in && cmd_ready_out;
    wire seq_op = is_seq_op(op_q);
    wire last_step = (step_q == 3'(nv_host_pkg::SEQ_LEN - 1));
    wire access_done = (cnt_q == nv_host_pkg::CNT_W'(nv_host_pkg::ACCESS_CYC - 1));
    wire gap_done = (cnt_q == nv_host_pkg::CNT_W'(nv_host_pkg::GAP_CYC - 1));
    wire pull_done = (cnt_q == nv_host_pkg::CNT_W'(nv_host_pkg::PULL_CYC - 1));
    wire lock_done = (cnt_q == nv_host_pkg::CNT_W'(nv_host_pkg::LOCKOUT_CYC));
    wire cur_write = (op_q == nv_host_pkg::CMD_WRITE);
    wire [nv_host_pkg::ADDR_W-1:0] cur_addr = seq_op ? seq_addr : addr_q;

    nv_seq_rom seq_rom (
        .step_in(step_q),
        .cmd_in(op_q),
        .addr_out(seq_addr)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 1'b1;
        case (state_q)
            ST_IDLE: begin
                cnt_d = '0;
                if (take_cmd) begin
                    state_d = ST_WAIT_BUSY;
                end
            end
            // Busy line low means a save/restore or lockout is pending
            ST_WAIT_BUSY: begin
                cnt_d = '0;
                if (op_q == nv_host_pkg::CMD_HW_STORE) begin
                    state_d = ST_PULL; // R12
                end else if (line_high) begin // R16 R20
                    state_d = ST_LOCKOUT; // R17
                end
            end
            // Lockout after line returns high; restart if it drops again
            ST_LOCKOUT: begin
                if (!line_high) begin
                    state_d = ST_WAIT_BUSY; // R20
                    cnt_d = '0;
                end else if (lock_done) begin
                    state_d = ST_ACCESS; // R17
                    cnt_d = '0;
                end
            end
            ST_ACCESS: begin
                if (access_done) begin
                    state_d = ST_GAP;
                    cnt_d = '0;
                end
            end
            ST_GAP: begin
                if (gap_done) begin
                    cnt_d = '0;
                    state_d = (seq_op && !last_step) ? ST_WAIT_BUSY : ST_IDLE; // R23
                end
            end
            // Host pull-down of the busy line, then wait for release
            ST_PULL: begin
                if (pull_done) begin
                    state_d = ST_WAIT_BUSY;
                    cnt_d = '0;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    // ----------------------------------------
    // Command capture and sequence step
    // ----------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            op_q <= nv_host_pkg::CMD_READ;
            addr_q <= '0;
            wdata_q <= '0;
            ben_q <= '0;
            step_q <= '0;
        end else if (take_cmd) begin
            op_q <= cmd_op_in;
            addr_q <= cmd_addr_in;
            wdata_q <= cmd_wdata_in;
            ben_q <= cmd_byte_en_in;
            step_q <= '0;
        end else if (state_q == ST_PULL && pull_done) begin
            // Pull done: later waits must not pull again
            op_q <= nv_host_pkg::CMD_READ; // R12
        end else if (state_q == ST_GAP && gap_done && seq_op && !last_step) begin
            step_q <= step_q + 1'b1; // R23
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Pin drive and response
    // ----------------------------------------
    wire in_access = (state_d == ST_ACCESS);
    wire finish_read = (state_q == ST_ACCESS) && access_done && !cur_write && !seq_op;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            chip_select_n_out <= 1'b1;
            chip_select_out <= 1'b0;
            write_strobe_n_out <= 1'b1; // R22
            output_enable_n_out <= 1'b1;
            upper_byte_select_n_out <= 1'b1;
            lower_byte_select_n_out <= 1'b1;
            sleep_request_n_out <= 1'b1; // R25
            mem_addr_out <= '0;
            data_pins_out <= '0;
            data_pins_oe_out <= 1'b0;
            store_busy_line_out <= 1'b0;
            store_busy_line_oe_out <= 1'b0;
            cmd_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
        end else begin
            sleep_request_n_out <= 1'b1; // R25
            chip_select_n_out <= !in_access; // R24
            chip_select_out <= in_access; // R24
            // Address held for the whole access window
            mem_addr_out <= in_access ? cur_addr : mem_addr_out; // R6 R2
            write_strobe_n_out <= !(in_access && cur_write); // R5 R23
            output_enable_n_out <= !(in_access && !cur_write); // R1 R7
            upper_byte_select_n_out <= !(in_access && (seq_op || ben_q[1])); // R3 R5
            lower_byte_select_n_out <= !(in_access && (seq_op || ben_q[0])); // R3 R5
            data_pins_out <= wdata_q;
            data_pins_oe_out <= in_access && cur_write; // R7
            store_busy_line_out <= 1'b0;
            store_busy_line_oe_out <= (state_d == ST_PULL); // R8 R12
            cmd_ready_out <= (state_d == ST_IDLE) && !take_cmd;
            rsp_valid_out <= finish_read || ((state_q == ST_GAP) && gap_done && cur_write);
            if (finish_read) begin
                rsp_rdata_out <= data_pins_in; // R4
            end
        end
    end

endmodule

// ### verification/nv_host_ctrl_sva.sv
`timescale 1ns/10ps
module nv_host_ctrl_sva (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [nv_host_pkg::ADDR_W-1:0] mem_addr_out,
    input wire logic chip_select_n_out,
    input wire logic chip_select_out,
    input wire logic write_strobe_n_out,
    input wire logic output_enable_n_out,
    input wire logic sleep_request_n_out,
    input wire logic data_pins_oe_out,
    input wire logic store_busy_line_in,
    input wire logic store_busy_line_oe_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    AST_SLEEP_HIGH: assert property (sleep_request_n_out)
        else $error("sleep request left active");
    AST_SELECT_PAIR: assert property (chip_select_out == !chip_select_n_out)
        else $error("select pins disagree");
    AST_OE_IN_WRITE: assert property (!write_strobe_n_out || data_pins_oe_out |-> output_enable_n_out)
        else $error("output enable low while writing");
    AST_WRITE_DRIVE: assert property (!write_strobe_n_out |-> data_pins_oe_out && !chip_select_n_out)
        else $error("write strobe without select or data");
    AST_ADDR_HELD: assert property (!write_strobe_n_out ##1 !write_strobe_n_out |-> $stable(mem_addr_out))
        else $error("address moved during write");
    AST_ACCESS_LEN: assert property ($fell(chip_select_n_out) |-> !chip_select_n_out[*6] ##1 chip_select_n_out)
        else $error("access window length wrong");
    AST_LOCKOUT: assert property (!store_busy_line_in && chip_select_n_out |=> chip_select_n_out[*3])
        else $error("access inside lockout");
    AST_PULL_IDLE: assert property (store_busy_line_oe_out |-> chip_select_n_out)
        else $error("access while pulling busy line");
    cover property ($fell(write_strobe_n_out));
    cover property ($rose(store_busy_line_oe_out));
    cover property (!store_busy_line_in && !store_busy_line_oe_out);
endmodule

bind nv_host_ctrl nv_host_ctrl_sva chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .mem_addr_out(mem_addr_out), .chip_select_n_out(chip_select_n_out),
    .chip_select_out(chip_select_out), .write_strobe_n_out(write_strobe_n_out),
    .output_enable_n_out(output_enable_n_out), .sleep_request_n_out(sleep_request_n_out),
    .data_pins_oe_out(data_pins_oe_out), .store_busy_line_in(store_busy_line_in),
    .store_busy_line_oe_out(store_busy_line_oe_out));

// ### verification/nv_mem_model.sv
`timescale 1ns/10ps
module nv_mem_model #(
    parameter int SAVE_CYC = 40,
    parameter int RESTORE_CYC = 50,
    parameter int GRACE_CYC = 5
) (
    input wire logic clock_in,
    input wire logic [19:0] addr_in,
    input wire logic select_n_in,
    input wire logic select_in,
    input wire logic write_n_in,
    input wire logic read_n_in,
    input wire logic upper_n_in,
    input wire logic lower_n_in,
    input wire logic sleep_n_in,
    input wire logic [15:0] data_in,
    input wire logic line_in,
    output logic [15:0] data_out = 16'h0000,
    output logic line_pull_out = 1'b1,
    output logic line_high_out = 1'b0
);
    logic [15:0] mem [logic [19:0]];
    logic [15:0] nv [logic [19:0]];
    logic [19:0] seq [5] = '{nv_host_pkg::SEQ_A0, nv_host_pkg::SEQ_A1, nv_host_pkg::SEQ_A2,
        nv_host_pkg::SEQ_A3, nv_host_pkg::SEQ_A4};
    int busy = RESTORE_CYC;
    int hi = 0, grace = -1, step = 0;
    bit latch = 0, autosave = 1, hi_after = 0, was_sel = 0, was_rd = 0;
    logic [19:0] last_a = 20'h0_0000;
    logic [15:0] word;
    logic sel, rd;
    // Combined select
    assign sel = !select_n_in && select_in && sleep_n_in;
    function automatic logic [15:0] peek(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 16'h0000;
    endfunction
    task automatic save;
        nv = mem;
        latch = 0;
        busy = SAVE_CYC;
        hi_after = 1;
    endtask
    // Save timing, accesses and sequence tracking
    always @(posedge clock_in) begin
        if (busy > 0) begin
            busy--;
            if (busy == 0 && hi_after) hi = 2;
        end else if (hi > 0) hi--;
        if (!line_in && busy == 0 && grace < 0 && latch) grace = GRACE_CYC;
        if (grace == 0) save();
        if (grace >= 0) grace--;
        if (sel && line_in && busy == 0 && !write_n_in) begin
            word = peek(addr_in);
            if (!lower_n_in) word[7:0] = data_in[7:0];
            if (!upper_n_in) word[15:8] = data_in[15:8];
            mem[addr_in] = word;
            latch = 1;
            step = 0;
        end
        word = peek(addr_in);
        rd = sel && line_in && busy == 0 && !read_n_in && write_n_in;
        data_out[7:0] <= (rd && !lower_n_in) ? word[7:0] : ~data_out[7:0];
        data_out[15:8] <= (rd && !upper_n_in) ? word[15:8] : ~data_out[15:8];
        if (was_sel && !sel && was_rd) begin
            if (step == 5) begin
                step = 0;
                if (last_a == nv_host_pkg::SEQ_STORE) save();
                if (last_a == nv_host_pkg::SEQ_SAVE_OFF) autosave = 0;
                if (last_a == nv_host_pkg::SEQ_SAVE_ON) autosave = 1;
                if (last_a == nv_host_pkg::SEQ_RECALL) begin
                    mem = nv;
                    latch = 0;
                    busy = RESTORE_CYC;
                    hi_after = 0;
                end
            end else step = (last_a == seq[step]) ? step + 1 : int'(last_a == seq[0]);
        end
        was_sel = sel;
        was_rd = rd;
        if (sel) last_a = addr_in;
        // Line drive updated after the edge, never racing the host
        line_pull_out <= busy > 0;
        line_high_out <= hi > 0;
    end
endmodule

// ### verification/nv_sram_store_recall_access_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module nv_sram_store_recall_access_tb_top;
    logic clock_in = 0, rst_n_in = 0, cmd_valid_in = 0;
    logic [2:0] cmd_op_in = 3'h0;
    logic [19:0] cmd_addr_in = 20'h0_0000;
    logic [15:0] cmd_wdata_in = 16'h0000;
    logic [1:0] cmd_byte_en_in = 2'h3;
    logic [15:0] rsp_rdata_out, data_pins_out, dev_data, data_pins_in, got;
    logic [19:0] mem_addr_out, a;
    logic cmd_ready_out, rsp_valid_out, cs_n, cs, we_n, oe_n, ub_n, lb_n, zz_n, data_oe;
    logic line_o, line_oe, dev_pull, dev_high, line, saw_rsp;
    int fail_count = 0, n_checks = 0, seed = 70, pulls = 0;
    logic [15:0] exp_mem [logic [19:0]];
    logic [15:0] nv_exp [logic [19:0]];
    logic [19:0] addrs [$];
    // Clock, wired busy line with pull-up, shared data bus
    always #4 clock_in = ~clock_in;
    assign line = dev_high || !((line_oe && !line_o) || dev_pull);
    assign data_pins_in = data_oe ? data_pins_out : dev_data;
    always @(posedge clock_in) pulls += int'(dev_pull === 1'b1);
    nv_host_ctrl dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
        .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
        .cmd_byte_en_in(cmd_byte_en_in), .cmd_ready_out(cmd_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
        .mem_addr_out(mem_addr_out), .chip_select_n_out(cs_n), .chip_select_out(cs),
        .write_strobe_n_out(we_n), .output_enable_n_out(oe_n), .upper_byte_select_n_out(ub_n),
        .lower_byte_select_n_out(lb_n), .sleep_request_n_out(zz_n),
        .data_pins_in(data_pins_in), .data_pins_out(data_pins_out), .data_pins_oe_out(data_oe),
        .store_busy_line_in(line), .store_busy_line_out(line_o), .store_busy_line_oe_out(line_oe));
    nv_mem_model dev (.clock_in(clock_in), .addr_in(mem_addr_out), .select_n_in(cs_n),
        .select_in(cs), .write_n_in(we_n), .read_n_in(oe_n), .upper_n_in(ub_n),
        .lower_n_in(lb_n), .sleep_n_in(zz_n), .data_in(data_pins_in), .line_in(line),
        .data_out(dev_data), .line_pull_out(dev_pull), .line_high_out(dev_high));
    task automatic report_and_stop;
        if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One command from offer to ready again
    task automatic do_cmd(input logic [2:0] op, input logic [19:0] ad, input logic [15:0] d,
            input logic [1:0] be);
        int n;
        n = 0;
        saw_rsp = 0;
        cmd_valid_in <= 1'b1;
        cmd_op_in <= op;
        cmd_addr_in <= ad;
        cmd_wdata_in <= d;
        cmd_byte_en_in <= be;
        do @(posedge clock_in); while (cmd_ready_out !== 1'b1);
        cmd_valid_in <= 1'b0;
        // Response may come at the very edge where ready returns
        do begin
            @(posedge clock_in);
            n++;
            if (rsp_valid_out === 1'b1) {saw_rsp, got} = {1'b1, rsp_rdata_out};
        end while (cmd_ready_out !== 1'b1 && n < 3000);
        `CHK("ready", 1'b1, cmd_ready_out)
    endtask
    task automatic wr(input logic [19:0] ad, input logic [15:0] d, input logic [1:0] be);
        logic [15:0] e;
        do_cmd(3'h1, ad, d, be);
        `CHK("write done", 1'b1, saw_rsp)
        e = exp_mem.exists(ad) ? exp_mem[ad] : 16'h0000;
        if (be[0]) e[7:0] = d[7:0];
        if (be[1]) e[15:8] = d[15:8];
        exp_mem[ad] = e;
    endtask
    task automatic rd_chk(input logic [19:0] ad, input logic [1:0] be);
        logic [15:0] e;
        do_cmd(3'h0, ad, 16'h0000, be);
        e = exp_mem.exists(ad) ? exp_mem[ad] : 16'h0000;
        `CHK("read done", 1'b1, saw_rsp)
        `CHK("read low lane", e[7:0], got[7:0])
        if (be[1]) `CHK("read high lane", e[15:8], got[15:8])
    endtask
    // Cut a hang short
    initial begin
        repeat (30000) @(posedge clock_in);
        fail_count++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        for (int i = 0; i < 12; i++) begin
            a = 20'($random(seed));
            wr(a, 16'($random(seed)), 2'($random(seed)));
            addrs.push_back(a);
        end
        foreach (addrs[i]) rd_chk(addrs[i], 2'h3);
        rd_chk(addrs[0], 2'h1);
        wr(addrs[1], 16'hA5C3, 2'h3);
        rd_chk(addrs[1], 2'h3);
        do_cmd(3'h2, 20'h0_0000, 16'h0000, 2'h3);
        nv_exp = exp_mem;
        wr(addrs[0], 16'h1234, 2'h3);
        do_cmd(3'h3, 20'h0_0000, 16'h0000, 2'h3);
        exp_mem = nv_exp;
        rd_chk(addrs[0], 2'h3);
        wr(addrs[2], 16'h5A5A, 2'h3);
        pulls = 0;
        do_cmd(3'h6, addrs[2], 16'h0000, 2'h3);
        nv_exp = exp_mem;
        `CHK("line save", 1'b1, pulls > 0)
        pulls = 0;
        do_cmd(3'h6, addrs[2], 16'h0000, 2'h3);
        `CHK("clear latch", 1'b1, pulls == 0)
        wr(addrs[2], 16'h0F0F, 2'h3);
        do_cmd(3'h3, 20'h0_0000, 16'h0000, 2'h3);
        exp_mem = nv_exp;
        rd_chk(addrs[2], 2'h3);
        do_cmd(3'h4, 20'h0_0000, 16'h0000, 2'h3);
        `CHK("power save off", 1'b0, dev.autosave)
        do_cmd(3'h5, 20'h0_0000, 16'h0000, 2'h3);
        `CHK("power save on", 1'b1, dev.autosave)
        rd_chk(addrs[3], 2'h3);
        report_and_stop();
    end
endmodule
